// ---- afe_setup_gain_offset_regs.sv ----
// Control register bank: sequencing, sample pulse detect, power, gain, offset
//
// Functional notes
// - Mode bit 0: 0 normal operation, 1 line-by-line operation.
// - Line-by-line forces single-channel mode 1 and single_channel_mode select red.
// - Line-by-line switches off green and blue gain amplifiers.
// - Pin-function bit ignored in normal mode; sets pin role line-by-line.
// - Select 0: pin clamps, muxes internal; select 1: pin pulses cycle.
// - While auto-cycling the pin never clamps; internal clamp bit decides.
// - Override enable lets override field drive input mux line-by-line only.
// - Line-by-line with auto-cycle: clamp bit 0 disables, 1 enables clamping.
// - Internal colour field 5:4: 00 red, 01 green, 10 blue, 11 reserved.
// - Override field 7:6: 00 red, 01 green, 10 blue, 11 reserved.
// - Edge detect off: sample pin passes straight to timing control.
// - Edge detect on: detected pin edge makes internal sync pulse.
// - Sync pulse delayed by 3-bit field master clocks when detect on.
// - Polarity bit: 0 falling edge, 1 rising edge, when detect on.
// - Power disable bits act only under selective power-down; 1 disables.
// - Bit 0 red, bit 1 green, bit 2 blue, bit 3 converter.
// - Separate 8-bit offsets per channel, reset to zero.
// - Broadcast offset write loads all three channel offsets.
// - 8-bit gain code per channel, reset zero; gain 208/(283-code).
// - Broadcast gain write loads all three channel gains.
// - Single_channel_mode select: 00 red, 01 green, 10 blue, 11 reserved.
// - Any write to cycle reset location returns the cycle counter to red.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module afe_setup_gain_offset_regs
   import afe_regs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regReadData,
   input wire logic samplePulsePin,
   input wire logic clampOrCyclePin,
   output logic timingSamplePulse,
   output path_ctrl_type pathCtrl,
   output logic [7:0] offsetRed,
   output logic [7:0] offsetGreen,
   output logic [7:0] offsetBlue,
   output logic [7:0] gainRed,
   output logic [7:0] gainGreen,
   output logic [7:0] gainBlue
);

   line_seq_type lineSeq;
   sample_det_type sampleDet;
   power_dis_type powerDis;
   mode_cfg_type modeCfg;
   colour_type cycleColour;
   logic [1:0] sampleSync;
   logic [1:0] cycleSync;
   logic samplePrev;
   logic cyclePrev;
   logic [2:0] delayCount;
   logic delayActive;
   logic edgeSeen;
   logic cyclePulse;
   logic autoCycle;
   logic next_pulse;
   path_ctrl_type next_path;

   function automatic logic isWrite(input logic [ADDR_W-1:0] a);
      isWrite = regWrite && (regAddr == a);
   endfunction : isWrite

   // Reserved colour code falls back to red rather than selecting nothing
   function automatic colour_type legalColour(input colour_type c);
      legalColour = (c == COLOUR_RSVD) ? COLOUR_RED : c;
   endfunction : legalColour

   function automatic colour_type nextColour(input colour_type c);
      unique case (c)
         COLOUR_RED: nextColour = COLOUR_GREEN;
         COLOUR_GREEN: nextColour = COLOUR_BLUE;
         default: nextColour = COLOUR_RED;
      endcase
   endfunction : nextColour

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lineSeq <= line_seq_type'(RESET_BYTE);
         sampleDet <= sample_det_type'(RESET_BYTE);
         powerDis <= power_dis_type'(RESET_BYTE);
         modeCfg <= mode_cfg_type'(RESET_BYTE);
      end
      else
      begin
         if (isWrite(ADDR_LINE_SEQ))
            lineSeq <= line_seq_type'(regWriteData);
         if (isWrite(ADDR_SAMPLE_DET))
            sampleDet <= sample_det_type'({4'h0, regWriteData[3:0] | 4'h0}
               | {3'h0, regWriteData[4], 4'h0});
         if (isWrite(ADDR_POWER_DIS))
            powerDis <= power_dis_type'({4'h0, regWriteData[3:0]});
         if (isWrite(ADDR_MODE_CFG))
            modeCfg <= mode_cfg_type'({3'h0, regWriteData[4:3], 1'b0,
               regWriteData[1:0]});
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         offsetRed <= RESET_BYTE;
         offsetGreen <= RESET_BYTE;
         offsetBlue <= RESET_BYTE;
      end
      else
      begin
         if (isWrite(ADDR_OFS_RED) || isWrite(ADDR_OFS_ALL))
            offsetRed <= regWriteData;
         if (isWrite(ADDR_OFS_GREEN) || isWrite(ADDR_OFS_ALL))
            offsetGreen <= regWriteData;
         if (isWrite(ADDR_OFS_BLUE) || isWrite(ADDR_OFS_ALL))
            offsetBlue <= regWriteData;
      end
   end

   // Codes go out raw; the analogue stage applies GAIN_NUM/(GAIN_DEN-code)
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gainRed <= RESET_BYTE;
         gainGreen <= RESET_BYTE;
         gainBlue <= RESET_BYTE;
      end
      else
      begin
         if (isWrite(ADDR_GAIN_RED) || isWrite(ADDR_GAIN_ALL))
            gainRed <= regWriteData;
         if (isWrite(ADDR_GAIN_GREEN) || isWrite(ADDR_GAIN_ALL))
            gainGreen <= regWriteData;
         if (isWrite(ADDR_GAIN_BLUE) || isWrite(ADDR_GAIN_ALL))
            gainBlue <= regWriteData;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         regReadData <= RESET_BYTE;
      else if (regRead)
      begin
         unique case (regAddr)
            ADDR_LINE_SEQ: regReadData <= lineSeq;
            ADDR_SAMPLE_DET: regReadData <= sampleDet;
            ADDR_POWER_DIS: regReadData <= powerDis;
            ADDR_MODE_CFG: regReadData <= modeCfg;
            ADDR_STATUS: regReadData <= {5'h0, autoCycle, cycleColour};
            ADDR_OFS_RED: regReadData <= offsetRed;
            ADDR_OFS_GREEN: regReadData <= offsetGreen;
            ADDR_OFS_BLUE: regReadData <= offsetBlue;
            ADDR_GAIN_RED: regReadData <= gainRed;
            ADDR_GAIN_GREEN: regReadData <= gainGreen;
            ADDR_GAIN_BLUE: regReadData <= gainBlue;
            // Broadcast, cycle reset and unmapped locations read zero
            default: regReadData <= RESET_BYTE;
         endcase
      end
      else
         regReadData <= RESET_BYTE;
   end

   // Pins come from outside; first stage is read only by the second
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sampleSync <= 2'h0;
         cycleSync <= 2'h0;
         samplePrev <= 1'b0;
         cyclePrev <= 1'b0;
      end
      else
      begin
         sampleSync <= {sampleSync[0], samplePulsePin};
         cycleSync <= {cycleSync[0], clampOrCyclePin};
         samplePrev <= sampleSync[1];
         cyclePrev <= cycleSync[1];
      end
   end

   assign autoCycle = lineSeq.lineSequentialMode
      && lineSeq.pinFunctionSelect;
   assign cyclePulse = autoCycle && cycleSync[1] && !cyclePrev;
   assign edgeSeen = sampleDet.edgePolaritySelect
      ? (sampleSync[1] && !samplePrev)
      : (!sampleSync[1] && samplePrev);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         cycleColour <= COLOUR_RED;
      else if (isWrite(ADDR_CYCLE_RST))
         cycleColour <= COLOUR_RED;
      else if (cyclePulse)
         cycleColour <= nextColour(cycleColour);
   end

   // A new edge during a pending delay restarts it; pulses cannot overlap
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         delayCount <= DELAY_ZERO;
         delayActive <= 1'b0;
      end
      else if (!sampleDet.sampleEdgeDetectEnable)
         delayActive <= 1'b0;
      else if (edgeSeen && sampleDet.samplePulseDelay != DELAY_ZERO)
      begin
         delayCount <= sampleDet.samplePulseDelay;
         delayActive <= 1'b1;
      end
      else if (delayActive)
      begin
         delayCount <= delayCount - DELAY_ONE;
         if (delayCount == DELAY_ONE)
            delayActive <= 1'b0;
      end
   end

   always_comb
   begin
      if (!sampleDet.sampleEdgeDetectEnable)
         next_pulse = sampleSync[1];
      else if (sampleDet.samplePulseDelay == DELAY_ZERO)
         next_pulse = edgeSeen;
      else
         next_pulse = delayActive && (delayCount == DELAY_ONE);
   end

   always_comb
   begin
      next_path.singleChannelMode = modeCfg.singleChannelMode;
      next_path.monoChannelSelect =
         legalColour(modeCfg.monoChannelSelect);
      next_path.gainOffsetSelect = COLOUR_RED;
      next_path.inputMuxSelect = COLOUR_RED;
      next_path.resetLevelClamp = cycleSync[1];
      next_path.greenGainOff = 1'b0;
      next_path.blueGainOff = 1'b0;
      if (lineSeq.lineSequentialMode)
      begin
         next_path.singleChannelMode = 1'b1;
         next_path.monoChannelSelect = COLOUR_RED;
         next_path.greenGainOff = 1'b1;
         next_path.blueGainOff = 1'b1;
         if (autoCycle)
         begin
            next_path.gainOffsetSelect = cycleColour;
            next_path.resetLevelClamp =
               lineSeq.internalClampEnable;
         end
         else
            next_path.gainOffsetSelect =
               legalColour(lineSeq.internalColourSelect);
         next_path.inputMuxSelect = lineSeq.inputOverrideEnable
            ? legalColour(lineSeq.overrideInputSelect)
            : next_path.gainOffsetSelect;
      end
      next_path.redPowerOff = modeCfg.selectivePowerdownEnable
         && powerDis.redOff;
      next_path.greenPowerOff = modeCfg.selectivePowerdownEnable
         && powerDis.greenOff;
      next_path.bluePowerOff = modeCfg.selectivePowerdownEnable
         && powerDis.blueOff;
      next_path.adcPowerOff = modeCfg.selectivePowerdownEnable
         && powerDis.adcOff;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timingSamplePulse <= 1'b0;
         pathCtrl <= '0;
      end
      else
      begin
         timingSamplePulse <= next_pulse;
         pathCtrl <= next_path;
      end
   end
endmodule : afe_setup_gain_offset_regs
`default_nettype wire

// ---- afe_regs_pkg.sv ----
// Register map, field layout and types for the front-end control bank
package afe_regs_pkg;
   localparam int ADDR_W = 5;
   localparam logic [4:0] ADDR_LINE_SEQ = 5'h04;
   localparam logic [4:0] ADDR_SAMPLE_DET = 5'h05;
   localparam logic [4:0] ADDR_POWER_DIS = 5'h06;
   localparam logic [4:0] ADDR_MODE_CFG = 5'h07;
   localparam logic [4:0] ADDR_CYCLE_RST = 5'h08;
   localparam logic [4:0] ADDR_STATUS = 5'h09;
   localparam logic [4:0] ADDR_OFS_RED = 5'h10;
   localparam logic [4:0] ADDR_OFS_GREEN = 5'h11;
   localparam logic [4:0] ADDR_OFS_BLUE = 5'h12;
   localparam logic [4:0] ADDR_OFS_ALL = 5'h13;
   localparam logic [4:0] ADDR_GAIN_RED = 5'h14;
   localparam logic [4:0] ADDR_GAIN_GREEN = 5'h15;
   localparam logic [4:0] ADDR_GAIN_BLUE = 5'h16;
   localparam logic [4:0] ADDR_GAIN_ALL = 5'h17;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] DELAY_ZERO = 3'h0;
   localparam logic [2:0] DELAY_ONE = 3'h1;
   // Gain law: gain = GAIN_NUM / (GAIN_DEN - code)
   localparam int GAIN_NUM = 208;
   localparam int GAIN_DEN = 283;

   typedef enum logic [1:0]
   {
      COLOUR_RED = 2'h0,
      COLOUR_GREEN = 2'h1,
      COLOUR_BLUE = 2'h2,
      COLOUR_RSVD = 2'h3
   } colour_type;

   typedef struct packed
   {
      colour_type overrideInputSelect;
      colour_type internalColourSelect;
      logic internalClampEnable;
      logic inputOverrideEnable;
      logic pinFunctionSelect;
      logic lineSequentialMode;
   } line_seq_type;

   typedef struct packed
   {
      logic [2:0] unused;
      logic edgePolaritySelect;
      logic [2:0] samplePulseDelay;
      logic sampleEdgeDetectEnable;
   } sample_det_type;

   typedef struct packed
   {
      logic [3:0] unused;
      logic adcOff;
      logic blueOff;
      logic greenOff;
      logic redOff;
   } power_dis_type;

   typedef struct packed
   {
      logic [2:0] unused;
      logic selectivePowerdownEnable;
      logic singleChannelMode;
      logic [0:0] pad;
      colour_type monoChannelSelect;
   } mode_cfg_type;

   typedef struct packed
   {
      logic singleChannelMode;
      colour_type monoChannelSelect;
      colour_type inputMuxSelect;
      colour_type gainOffsetSelect;
      logic resetLevelClamp;
      logic redPowerOff;
      logic greenPowerOff;
      logic bluePowerOff;
      logic adcPowerOff;
      logic greenGainOff;
      logic blueGainOff;
   } path_ctrl_type;
endpackage : afe_regs_pkg

// ---- afe_regs_chk.sv ----
// Port assertions for the front-end control bank
`timescale 1ns/10ps
`default_nettype none
module afe_regs_chk
   import afe_regs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic samplePulsePin,
   input wire logic clampOrCyclePin,
   input wire logic timingSamplePulse,
   input wire path_ctrl_type pathCtrl,
   input wire logic [7:0] offsetRed,
   input wire logic [7:0] offsetGreen,
   input wire logic [7:0] offsetBlue,
   input wire logic [7:0] gainRed,
   input wire logic [7:0] gainGreen,
   input wire logic [7:0] gainBlue
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   a_gain_bcast: assert property (
      regWrite && regAddr == ADDR_GAIN_ALL |=> gainRed == $past(regWriteData)
      && gainGreen == gainRed && gainBlue == gainRed)
      else $error("broadcast gain not loaded");
   a_ofs_bcast: assert property (
      regWrite && regAddr == ADDR_OFS_ALL |=> offsetRed == $past(regWriteData)
      && offsetGreen == offsetRed && offsetBlue == offsetRed)
      else $error("broadcast offset not loaded");
   a_gain_hold: assert property (
      !(regWrite && (regAddr == ADDR_GAIN_RED || regAddr == ADDR_GAIN_ALL))
      |=> $stable(gainRed))
      else $error("red gain changed without write");
   a_ofs_hold: assert property (
      !(regWrite && (regAddr == ADDR_OFS_BLUE || regAddr == ADDR_OFS_ALL))
      |=> $stable(offsetBlue))
      else $error("blue offset changed without write");
   a_gain_read: assert property (
      regRead && regAddr == ADDR_GAIN_GREEN |=> regReadData == gainGreen)
      else $error("green gain read wrong");
   a_bcast_read: assert property (
      regRead && (regAddr == ADDR_OFS_ALL || regAddr == ADDR_GAIN_ALL)
      |=> regReadData == 8'h00)
      else $error("broadcast location read not zero");
   a_line_force: assert property (
      regWrite && regAddr == ADDR_LINE_SEQ && regWriteData[0] |=> ##1
      pathCtrl.singleChannelMode && pathCtrl.monoChannelSelect == COLOUR_RED
      && pathCtrl.greenGainOff && pathCtrl.blueGainOff)
      else $error("line mode did not force path");
   a_normal_mux: assert property (
      regWrite && regAddr == ADDR_LINE_SEQ && !regWriteData[0] |=> ##1
      pathCtrl.inputMuxSelect == COLOUR_RED && !pathCtrl.greenGainOff)
      else $error("normal mode path wrong");
endmodule : afe_regs_chk
`default_nettype wire

// ---- afe_host.sv ----
// Host model issuing register writes and reads
`timescale 1ns/10ps
`default_nettype none
module afe_host
   import afe_regs_pkg::*;
(
   input wire logic ref_clk,
   output logic [ADDR_W-1:0] regAddr,
   output logic [7:0] regWriteData,
   output logic regWrite,
   output logic regRead
);
   initial
      {regAddr, regWriteData, regWrite, regRead} = '0;
   // Data inverted after a write so stale values never look valid
   task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      regWriteData <= ~d;
   endtask : wr
   task rd(input logic [ADDR_W-1:0] a);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
   endtask : rd
endmodule : afe_host
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the front-end control bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import afe_regs_pkg::*;
   logic ref_clk, rst_n, samplePulsePin, clampOrCyclePin, rdSeen;
   logic timingSamplePulse, regWrite, regRead;
   logic [ADDR_W-1:0] regAddr;
   logic [7:0] regWriteData, regReadData, d;
   logic [7:0] offsetRed, offsetGreen, offsetBlue, gainRed, gainGreen, gainBlue;
   path_ctrl_type pathCtrl;
   logic [3:0] pwr;
   logic [4:0] single_channel_mode;
   logic [7:0] expQ[$];
   int fails, n_tests, n, d0;
   assign pwr = {pathCtrl.adcPowerOff, pathCtrl.bluePowerOff,
      pathCtrl.greenPowerOff, pathCtrl.redPowerOff};
   assign single_channel_mode = {pathCtrl.singleChannelMode, pathCtrl.monoChannelSelect,
      pathCtrl.greenGainOff, pathCtrl.blueGainOff};
   afe_setup_gain_offset_regs dut_u (.ref_clk, .rst_n, .regAddr,
      .regWriteData, .regWrite, .regRead, .regReadData, .samplePulsePin,
      .clampOrCyclePin, .timingSamplePulse, .pathCtrl, .offsetRed,
      .offsetGreen, .offsetBlue, .gainRed, .gainGreen, .gainBlue);
   afe_host host_u (.ref_clk, .regAddr, .regWriteData, .regWrite, .regRead);
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e)
      begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask : chk
   task wrap_up;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   always @(posedge ref_clk)
   begin
      if (rdSeen === 1'b1)
         chk(regReadData, expQ.pop_front());
      rdSeen <= regRead;
   end
   task rdx(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      expQ.push_back(e);
      host_u.rd(a);
   endtask : rdx
   task settle;
      repeat (5) @(posedge ref_clk);
      #1;
   endtask : settle
   task pulse(input logic e);
      @(posedge ref_clk);
      clampOrCyclePin <= 1'b1;
      settle();
      chk(8'(pathCtrl.resetLevelClamp), 8'(e));
      @(posedge ref_clk);
      clampOrCyclePin <= 1'b0;
      settle();
   endtask : pulse
   // Counts edges from pin change to the timing output going high
   task meas(input logic v, output int k);
      @(posedge ref_clk);
      samplePulsePin <= v;
      k = 0;
      #1;
      while (timingSamplePulse !== 1'b1)
      begin
         if (k == 20)
         begin
            fails++;
            wrap_up();
         end
         @(posedge ref_clk);
         #1;
         k++;
      end
   endtask : meas
   initial
   begin
      {rst_n, samplePulsePin, clampOrCyclePin} = '0;
      fails = 0;
      n_tests = 0;
      void'($urandom(32'h2e63_fd86));
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 32; i++)
         rdx(5'(i), 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         d = 8'($urandom);
         host_u.wr(ADDR_OFS_RED + 5'(i + i / 3), d);
         rdx(ADDR_OFS_RED + 5'(i + i / 3), d);
      end
      for (int k = 0; k < 2; k++)
      begin
         d = 8'($urandom);
         host_u.wr(k == 1 ? ADDR_GAIN_ALL : ADDR_OFS_ALL, d);
         for (int i = 0; i < 4; i++)
            rdx(5'(16 + 4 * k + i), i == 3 ? 8'h00 : d);
      end
      host_u.wr(ADDR_SAMPLE_DET, 8'hFF);
      rdx(ADDR_SAMPLE_DET, 8'h1F);
      host_u.wr(ADDR_MODE_CFG, 8'hFF);
      rdx(ADDR_MODE_CFG, 8'h1B);
      for (int k = 5; k < 16; k += 5)
      begin
         host_u.wr(ADDR_POWER_DIS, 8'(k));
         settle();
         chk(8'(pwr), 8'(k));
      end
      host_u.wr(ADDR_MODE_CFG, 8'h0A);
      settle();
      chk(8'(pwr), 8'h00);
      chk(8'(single_channel_mode), 8'h18);
      host_u.wr(ADDR_LINE_SEQ, 8'h01);
      settle();
      chk(8'(single_channel_mode), 8'h13);
      for (int c = 0; c < 4; c++)
      begin
         host_u.wr(ADDR_LINE_SEQ, 8'(c * 16 + 1));
         settle();
         chk(8'(pathCtrl.gainOffsetSelect), c == 3 ? 8'h00 : 8'(c));
         host_u.wr(ADDR_LINE_SEQ, 8'(c * 64 + 21));
         settle();
         chk(8'(pathCtrl.inputMuxSelect), c == 3 ? 8'h00 : 8'(c));
      end
      pulse(1'b1);
      host_u.wr(ADDR_LINE_SEQ, 8'h86);
      settle();
      chk(8'(pathCtrl.inputMuxSelect), 8'h00);
      pulse(1'b1);
      host_u.wr(ADDR_CYCLE_RST, 8'h00);
      host_u.wr(ADDR_LINE_SEQ, 8'h03);
      settle();
      chk(8'(pathCtrl.gainOffsetSelect), 8'h00);
      for (int i = 1; i < 5; i++)
      begin
         pulse(1'b0);
         chk(8'(pathCtrl.gainOffsetSelect), 8'(i % 3));
      end
      host_u.wr(ADDR_LINE_SEQ, 8'h0B);
      pulse(1'b1);
      host_u.wr(ADDR_CYCLE_RST, 8'h5A);
      settle();
      chk(8'(pathCtrl.gainOffsetSelect), 8'h00);
      host_u.wr(ADDR_SAMPLE_DET, 8'h00);
      settle();
      meas(1'b1, n);
      chk(8'(n), 8'h03);
      settle();
      chk(8'(timingSamplePulse), 8'h01);
      host_u.wr(ADDR_SAMPLE_DET, 8'h01);
      settle();
      meas(1'b0, d0);
      @(posedge ref_clk);
      #1;
      chk(8'(timingSamplePulse), 8'h00);
      host_u.wr(ADDR_SAMPLE_DET, 8'h17);
      settle();
      meas(1'b1, n);
      chk(8'(n), 8'(d0 + 3));
      host_u.wr(ADDR_SAMPLE_DET, 8'h0F);
      settle();
      meas(1'b0, n);
      chk(8'(n), 8'(d0 + 7));
      wrap_up();
   end
endmodule : testbench
bind afe_setup_gain_offset_regs afe_regs_chk chk_u (.ref_clk, .rst_n,
   .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
   .samplePulsePin, .clampOrCyclePin, .timingSamplePulse, .pathCtrl,
   .offsetRed, .offsetGreen, .offsetBlue, .gainRed, .gainGreen, .gainBlue);
`default_nettype wire
